// ===== cmt_timer.sv
module cmt_timer import cmt_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Write address channel
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_awaddr,
    // Write data channel
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // Write response channel
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // Read address channel
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [31:0] s_axi_araddr,
    // Read data channel
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Interrupt
    output logic irq,
    // Compare pin
    output logic cmpPinOut,
    output logic cmpPinOe
);
    // ****************************************************************
    // Address decoding
    // ****************************************************************

    // Maps a byte address onto a register; used for reads and writes
    function automatic cmt_reg_e regSel(input logic [31:0] addr);
        cmt_reg_e sel;
        sel = SEL_NONE;
        if (addr[1:0] == 2'h0 && addr[31:18] == 14'h0000) begin
            unique case (addr[17:2])
                IDX_CTRL: sel = SEL_CTRL;
                IDX_IOC: sel = SEL_IOC;
                IDX_STAT: sel = SEL_STAT;
                IDX_IEN: sel = SEL_IEN;
                IDX_CNT: sel = SEL_CNT;
                IDX_GRA: sel = SEL_GRA;
                IDX_START: sel = SEL_START;
                default: sel = SEL_NONE;
            endcase
        end
        return sel;
    endfunction

    // ****************************************************************
    // Submodules
    // ****************************************************************

    cmt_cnt_if cntIf ();    // Counter link

    logic countTick;        // Selected count clock edge
    logic [7:0] ctrl_q, ctrl_d;     // Counter control, declared ahead of the prescaler

    // Count clock source
    cmt_prescaler cmt_prescaler_inst (
        .clk(clk),
        .rst(rst),
        .pscSel(ctrl_q[PSC_LSB +: 3]),
        .edgeSel(ctrl_q[EDGE_LSB +: 2]),
        .countTick(countTick)
    );

    // Counter and comparator
    cmt_counter cmt_counter_inst (
        .clk(clk),
        .rst(rst),
        .bus(cntIf)
    );

    // ****************************************************************
    // Write path state
    // ****************************************************************

    logic awReady_q, awReady_d;     // Address slot free
    logic wReady_q, wReady_d;       // Data slot free
    logic awHeld_q, awHeld_d;       // Address captured
    logic wHeld_q, wHeld_d;         // Data captured
    logic [31:0] awAddr_q, awAddr_d;
    logic [31:0] wData_q, wData_d;
    logic [3:0] wStrb_q, wStrb_d;
    logic bValid_q, bValid_d;
    logic [1:0] bResp_q, bResp_d;
    logic doWrite;                  // Both halves present
    cmt_reg_e wrSel;                // Target of the write

    // Address and data are taken in either order, then one write
    always_comb begin
        awHeld_d = awHeld_q;
        wHeld_d = wHeld_q;
        awAddr_d = awAddr_q;
        wData_d = wData_q;
        wStrb_d = wStrb_q;
        bValid_d = bValid_q;
        bResp_d = bResp_q;
        doWrite = awHeld_q && wHeld_q;
        wrSel = regSel(awAddr_q);
        // Capture address
        if (s_axi_awvalid && awReady_q) begin
            awHeld_d = 1'b1;
            awAddr_d = s_axi_awaddr;
        end
        // Capture data
        if (s_axi_wvalid && wReady_q) begin
            wHeld_d = 1'b1;
            wData_d = s_axi_wdata;
            wStrb_d = s_axi_wstrb;
        end
        // Perform the write and raise the response
        if (doWrite) begin
            awHeld_d = 1'b0;
            wHeld_d = 1'b0;
            bValid_d = 1'b1;
            bResp_d = (wrSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (bValid_q && s_axi_bready) begin
            bValid_d = 1'b0;
        end
        // No new transfer until the response is gone
        awReady_d = !awHeld_d && !bValid_d && !doWrite;
        wReady_d = !wHeld_d && !bValid_d && !doWrite;
    end

    // Write path registers
    always_ff @(posedge clk) begin
        if (rst) begin
            awReady_q <= 1'b0;
            wReady_q <= 1'b0;
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 32'h00000000;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
            bValid_q <= 1'b0;
            bResp_q <= RESP_OKAY;
        end else begin
            awReady_q <= awReady_d;
            wReady_q <= wReady_d;
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            awAddr_q <= awAddr_d;
            wData_q <= wData_d;
            wStrb_q <= wStrb_d;
            bValid_q <= bValid_d;
            bResp_q <= bResp_d;
        end
    end

    // ****************************************************************
    // Timer registers
    // ****************************************************************

    logic [7:0] ioc_q, ioc_d;       // Compare I/O control
    logic flag_q, flag_d;           // Match flag A
    logic ien_q, ien_d;             // Match interrupt enable A
    logic [15:0] gra_q, gra_d;      // General compare A
    logic start_q, start_d;         // Channel start
    logic irq_q, irq_d;
    logic pinOut_q, pinOut_d;
    logic pinOe_q, pinOe_d;
    logic wrLo;                     // Byte lane 0 written
    logic wrHi;                     // Byte lane 1 written

    // Register writes, flag, interrupt and pin
    always_comb begin
        wrLo = doWrite && wStrb_q[0];
        wrHi = doWrite && wStrb_q[1];
        ctrl_d = ctrl_q;
        ioc_d = ioc_q;
        ien_d = ien_q;
        gra_d = gra_q;
        start_d = start_q;
        if (wrLo && wrSel == SEL_CTRL) begin
            ctrl_d = wData_q[7:0];
        end
        if (wrLo && wrSel == SEL_IOC) begin
            ioc_d = wData_q[7:0];
        end
        if (wrLo && wrSel == SEL_IEN) begin
            ien_d = wData_q[MATCH_IEN_BIT];
        end
        if (wrLo && wrSel == SEL_START) begin
            start_d = wData_q[START_BIT];
        end
        // Compare value, lane by lane
        if (wrLo && wrSel == SEL_GRA) begin
            gra_d[7:0] = wData_q[7:0];
        end
        if (wrHi && wrSel == SEL_GRA) begin
            gra_d[15:8] = wData_q[15:8];
        end
        // Flag: a match in the clearing cycle still sets it
        flag_d = flag_q;
        if (wrLo && wrSel == SEL_STAT && wData_q[MATCH_FLAG_BIT]) begin
            flag_d = 1'b0;
        end
        if (cntIf.matchPulse) begin
            flag_d = 1'b1;
        end
        // Request follows flag and enable; capture modes are not built,
        // so the same gating holds whatever the top I/O bit says
        irq_d = flag_q && ien_q;
        // Pin: code 000 leaves it undriven, capture codes too
        pinOut_d = pinOut_q;
        pinOe_d = 1'b0;
        if (!ioc_q[IO_CAPTURE_BIT] && ioc_q[2:0] != IO_NO_PIN) begin
            pinOe_d = 1'b1;
            if (cntIf.matchPulse) begin
                if (ioc_q[2:0] == IO_PIN_LOW) begin
                    pinOut_d = 1'b0;
                end else if (ioc_q[2:0] == IO_PIN_HIGH) begin
                    pinOut_d = 1'b1;
                end else begin
                    pinOut_d = ~pinOut_q;
                end
            end
        end
    end

    // Timer register storage
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= CTRL_RST;
            ioc_q <= IOC_RST;
            flag_q <= 1'b0;
            ien_q <= 1'b0;
            gra_q <= GRA_RST;
            start_q <= 1'b0;
            irq_q <= 1'b0;
            pinOut_q <= 1'b0;
            pinOe_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            ioc_q <= ioc_d;
            flag_q <= flag_d;
            ien_q <= ien_d;
            gra_q <= gra_d;
            start_q <= start_d;
            irq_q <= irq_d;
            pinOut_q <= pinOut_d;
            pinOe_q <= pinOe_d;
        end
    end

    // Counter link drive; a software load beats counting
    always_comb begin
        cntIf.clrSel = ctrl_q[CLR_LSB +: 3];
        cntIf.start = start_q;
        cntIf.tick = countTick;
        cntIf.gra = gra_q;
        cntIf.wrEn = wrSel == SEL_CNT && (wrLo || wrHi);
        cntIf.wrData = cntIf.count;
        if (wrLo) begin
            cntIf.wrData[7:0] = wData_q[7:0];
        end
        if (wrHi) begin
            cntIf.wrData[15:8] = wData_q[15:8];
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************

    logic arReady_q, arReady_d;
    logic rValid_q, rValid_d;
    logic [31:0] rData_q, rData_d;
    logic [1:0] rResp_q, rResp_d;
    cmt_reg_e rdSel;

    // One read at a time; data one cycle after the address is taken
    always_comb begin
        rdSel = regSel(s_axi_araddr);
        rValid_d = rValid_q;
        rData_d = rData_q;
        rResp_d = rResp_q;
        if (s_axi_arvalid && arReady_q) begin
            rValid_d = 1'b1;
            rResp_d = RESP_OKAY;
            rData_d = 32'h00000000;     // Unused bits read zero
            unique case (rdSel)
                SEL_CTRL: rData_d[7:0] = ctrl_q;
                SEL_IOC: rData_d[7:0] = ioc_q;
                SEL_STAT: rData_d[MATCH_FLAG_BIT] = flag_q;
                SEL_IEN: rData_d[MATCH_IEN_BIT] = ien_q;
                SEL_CNT: rData_d[15:0] = cntIf.count;
                SEL_GRA: rData_d[15:0] = gra_q;
                SEL_START: rData_d[START_BIT] = start_q;
                SEL_NONE: rResp_d = RESP_SLVERR;
            endcase
        end else if (rValid_q && s_axi_rready) begin
            rValid_d = 1'b0;
        end
        arReady_d = !rValid_d;
    end

    // Read path registers
    always_ff @(posedge clk) begin
        if (rst) begin
            arReady_q <= 1'b0;
            rValid_q <= 1'b0;
            rData_q <= 32'h00000000;
            rResp_q <= RESP_OKAY;
        end else begin
            arReady_q <= arReady_d;
            rValid_q <= rValid_d;
            rData_q <= rData_d;
            rResp_q <= rResp_d;
        end
    end

    // ****************************************************************
    // Outputs, all from flip-flops
    // ****************************************************************

    assign s_axi_awready = awReady_q;
    assign s_axi_wready = wReady_q;
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;
    assign s_axi_arready = arReady_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rdata = rData_q;
    assign s_axi_rresp = rResp_q;
    assign irq = irq_q;
    assign cmpPinOut = pinOut_q;
    assign cmpPinOe = pinOe_q;
endmodule

// ===== cmt_pkg.sv
// ****************************************************************
// Shared constants for the compare-match interval timer
// ****************************************************************
package cmt_pkg;
    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_CTRL = 16'hF700;
    localparam logic [15:0] IDX_IOC = 16'hF701;
    localparam logic [15:0] IDX_STAT = 16'hF703;
    localparam logic [15:0] IDX_IEN = 16'hF704;
    localparam logic [15:0] IDX_CNT = 16'hF706;
    localparam logic [15:0] IDX_GRA = 16'hF708;
    localparam logic [15:0] IDX_START = 16'hF720;
    // Field positions
    localparam int CLR_LSB = 5;
    localparam int EDGE_LSB = 3;
    localparam int PSC_LSB = 0;
    localparam int IO_CAPTURE_BIT = 2;
    localparam int MATCH_FLAG_BIT = 0;
    localparam int MATCH_IEN_BIT = 0;
    localparam int START_BIT = 0;
    // Field codes
    localparam logic [2:0] CLR_ON_A = 3'h1;
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [2:0] PSC_DIV1 = 3'h0;
    localparam logic [2:0] PSC_DIV2 = 3'h1;
    localparam logic [2:0] PSC_DIV4 = 3'h2;
    localparam logic [2:0] PSC_DIV8 = 3'h3;
    localparam logic [2:0] IO_NO_PIN = 3'h0;
    localparam logic [2:0] IO_PIN_LOW = 3'h1;
    localparam logic [2:0] IO_PIN_HIGH = 3'h2;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] IOC_RST = 8'h00;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] GRA_RST = 16'hFFFF;
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Register selected by an address
    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_CTRL = 3'b001,
        SEL_IOC = 3'b010,
        SEL_STAT = 3'b011,
        SEL_IEN = 3'b100,
        SEL_CNT = 3'b101,
        SEL_GRA = 3'b110,
        SEL_START = 3'b111
    } cmt_reg_e;
endpackage

// ===== cmt_cnt_if.sv
// ****************************************************************
// Link between the register file and the channel counter
// ****************************************************************
interface cmt_cnt_if;
    logic [2:0] clrSel;     // Counter clear selection
    logic start;            // Channel start
    logic tick;             // Selected count clock edge
    logic [15:0] gra;       // Compare value A
    logic wrEn;             // Software load of the counter
    logic [15:0] wrData;    // Value to load
    logic [15:0] count;     // Present count
    logic matchPulse;       // One-cycle compare match A
    modport regs (output clrSel, start, tick, gra, wrEn, wrData, input count, matchPulse);
    modport cnt (input clrSel, start, tick, gra, wrEn, wrData, output count, matchPulse);
endinterface

// ===== cmt_prescaler.sv
// ****************************************************************
// Count clock selection and edge detection
// ****************************************************************
module cmt_prescaler import cmt_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Selection
    input wire logic [2:0] pscSel,
    input wire logic [1:0] edgeSel,
    // Count enable
    output logic countTick
);
    logic [2:0] div_q, div_d;   // Free-running divider
    logic lvl_q, lvl_d;         // Last divided level
    logic tick_q, tick_d;
    logic lvl;

    // Divided clock, edge picking and next values
    always_comb begin
        div_d = div_q + 3'h1;
        unique case (pscSel)
            PSC_DIV2: lvl = div_q[0];
            PSC_DIV4: lvl = div_q[1];
            PSC_DIV8: lvl = div_q[2];
            default: lvl = 1'b0;        // External clocks are not wired
        endcase
        lvl_d = lvl;
        if (pscSel == PSC_DIV1) begin
            tick_d = 1'b1;              // Undivided: every cycle counts
        end else if (edgeSel == EDGE_RISE) begin
            tick_d = lvl & ~lvl_q;
        end else if (edgeSel == EDGE_FALL) begin
            tick_d = ~lvl & lvl_q;
        end else begin
            tick_d = lvl ^ lvl_q;       // Both edges
        end
    end

    // Registers
    always_ff @(posedge clk) begin
        if (rst) begin
            div_q <= 3'h0;
            lvl_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_d;
            lvl_q <= lvl_d;
            tick_q <= tick_d;
        end
    end

    assign countTick = tick_q;
endmodule

// ===== cmt_counter.sv
// ****************************************************************
// Channel counter with compare match A
// ****************************************************************
module cmt_counter import cmt_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control and status
    cmt_cnt_if.cnt bus
);
    logic [15:0] cnt_q, cnt_d;      // Channel counter
    logic match_q, match_d;         // Match event
    logic equal;

    // Next count and match detection
    always_comb begin
        equal = (cnt_q == bus.gra);
        cnt_d = cnt_q;
        match_d = 1'b0;
        if (bus.wrEn) begin
            cnt_d = bus.wrData;
        end else if (bus.start && bus.tick) begin
            match_d = equal;
            if (equal && bus.clrSel == CLR_ON_A) begin
                cnt_d = 16'h0000;
            end else begin
                cnt_d = cnt_q + 16'h0001;
            end
        end
    end

    // Registers
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= CNT_RST;
            match_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            match_q <= match_d;
        end
    end

    assign bus.count = cnt_q;
    assign bus.matchPulse = match_q;
endmodule

// ===== cmt_timer_asserts.sv
module cmt_timer_asserts import cmt_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Write channels
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read channels
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Outputs under watch
    input wire logic irq,
    input wire logic cmpPinOe
);
    // ********************************
    // Shadow of the match enable bit
    // ********************************
    logic ienQ; // Enable as software last wrote it
    logic ienD; // Next shadow value
    logic wrIen; // Enable write taken on both channels at once
    assign wrIen = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_awaddr == {14'h0, IDX_IEN, 2'h0} && s_axi_wstrb[0];
    // Seen from the bus, so it leads the design's own bit by one cycle
    always_comb begin
        ienD = ienQ;
        if (wrIen) begin
            ienD = s_axi_wdata[MATCH_IEN_BIT];
        end
    end
    // Register the shadow
    always_ff @(posedge clk) begin
        ienQ <= rst ? 1'b0 : ienD;
    end
    // ********************************
    // Properties
    // ********************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_reset_quiet: assert property (disable iff (1'b0) rst |=> !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs active after reset");
    a_pin_undriven: assert property (!cmpPinOe)
        else $error("compare pin driven");
    a_irq_needs_en: assert property (irq |-> ienQ || $past(ienQ) || $past(ienQ, 2) || $past(ienQ, 3))
        else $error("interrupt without enable");
    a_irq_drops_fast: assert property ($fell(ienQ) |-> ##[1:3] !irq)
        else $error("interrupt kept after disable");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_wr_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
        ##1 (s_axi_awready && s_axi_wready))
        else $error("write channel not released");
    a_rd_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready)
        else $error("read channel not released");
    a_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
endmodule

bind cmt_timer cmt_timer_asserts cmt_timer_asserts_inst (.clk(clk), .rst(rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq(irq), .cmpPinOe(cmpPinOe));

// ===== cmt_timer_tb.sv
module cmt_timer_tb import cmt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ********************************
    // Signals and bookkeeping
    // ********************************
    typedef struct packed {logic [31:0] data; logic [1:0] resp;} cmt_exp_s;
    logic clk, rst, irq, cmpPinOut, cmpPinOe;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    cmt_exp_s rdQ[$]; // Expected read answers, oldest first
    logic [1:0] bQ[$]; // Expected write responses
    int fails = 0;
    int num_checks = 0;
    int cyc = 0; // Free cycle count for period timing
    logic [7:0] lfsr = 8'h38; // Random source
    cmt_timer cmt_timer_inst (.clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .irq(irq),
        .cmpPinOut(cmpPinOut), .cmpPinOe(cmpPinOe));
    // ********************************
    // Helpers
    // ********************************
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Write: both channels offered together, held until each is taken
    task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
        bQ.push_back(er);
        s_axi_awaddr <= {14'h0, idx, 2'h0};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        @(posedge clk); // Gap so no signal is driven twice in one step
    endtask
    // Read: expectation queued first, the monitor compares it
    task automatic rd(input logic [15:0] idx, input logic [31:0] ed, input logic [1:0] er);
        rdQ.push_back({ed, er});
        s_axi_araddr <= {14'h0, idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask
    // Cycle stamp of the next rising interrupt
    task automatic irq_rise(output int t);
        do @(posedge clk); while (irq !== 1'b0);
        do @(posedge clk); while (irq !== 1'b1);
        t = cyc;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ********************************
    // Clock, monitor, watchdog
    // ********************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Responses compared against the oldest note as they are handed over
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
            check_resp("bresp", bQ.pop_front(), s_axi_bresp);
        end
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            check_word("rdata", rdQ[0].data, s_axi_rdata);
            check_resp("rresp", rdQ[0].resp, s_axi_rresp);
            void'(rdQ.pop_front());
        end
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        tally_and_finish();
    end
    // ********************************
    // Tests
    // ********************************
    initial begin
        int t1;
        int t2;
        int g;
        logic [15:0] gv;
        rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 32'h0;
        s_axi_araddr = 32'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(IDX_CTRL, {24'h0, CTRL_RST}, RESP_OKAY);
        rd(IDX_IOC, {24'h0, IOC_RST}, RESP_OKAY);
        rd(IDX_STAT, 32'h0, RESP_OKAY);
        rd(IDX_CNT, {16'h0, CNT_RST}, RESP_OKAY);
        rd(IDX_GRA, {16'h0, GRA_RST}, RESP_OKAY);
        rd(16'hF702, 32'h0, RESP_SLVERR);
        wr(16'hF702, 32'h0000_00FF, RESP_SLVERR);
        $display("test reset_and_map done");
        // Stopped counter keeps a random loaded value
        lfsr = lfsr_next(lfsr);
        gv[7:0] = lfsr;
        lfsr = lfsr_next(lfsr);
        gv[15:8] = lfsr;
        wr(IDX_CNT, {16'h0, gv}, RESP_OKAY);
        repeat (20) @(posedge clk);
        rd(IDX_CNT, {16'h0, gv}, RESP_OKAY);
        $display("test counter_hold done");
        // Interval mode: clear on A, rising edge, clock over four, pin off
        wr(IDX_CTRL, {24'h0, CLR_ON_A, EDGE_RISE, PSC_DIV4}, RESP_OKAY);
        wr(IDX_IOC, {29'h0, IO_NO_PIN}, RESP_OKAY);
        wr(IDX_IEN, 32'h1, RESP_OKAY);
        for (int i = 0; i < 2; i++) begin
            lfsr = lfsr_next(lfsr);
            g = 3 + int'(lfsr[2:0]);
            wr(IDX_START, 32'h0, RESP_OKAY);
            wr(IDX_GRA, 32'(g), RESP_OKAY);
            wr(IDX_CNT, 32'h0, RESP_OKAY);
            wr(IDX_STAT, 32'h1, RESP_OKAY);
            wr(IDX_START, 32'h1, RESP_OKAY);
            irq_rise(t1);
            rd(IDX_STAT, 32'h1, RESP_OKAY);
            wr(IDX_STAT, 32'h1, RESP_OKAY);
            irq_rise(t2);
            check_word("period", 32'(4 * (g + 1)), 32'(t2 - t1));
        end
        $display("test interval done");
        // Masking while the flag stays set
        wr(IDX_IEN, 32'h0, RESP_OKAY);
        repeat (3) @(posedge clk);
        check_word("irq", 32'h0, {31'h0, irq});
        rd(IDX_STAT, 32'h1, RESP_OKAY);
        wr(IDX_IEN, 32'h1, RESP_OKAY);
        repeat (3) @(posedge clk);
        check_word("irq", 32'h1, {31'h0, irq});
        wr(IDX_START, 32'h0, RESP_OKAY);
        wr(IDX_STAT, 32'h1, RESP_OKAY);
        rd(IDX_STAT, 32'h0, RESP_OKAY);
        check_word("irq", 32'h0, {31'h0, irq});
        check_word("pin", 32'h0, {30'h0, cmpPinOe, cmpPinOut});
        $display("test masking done");
        tally_and_finish();
    end
endmodule
